/* testbench/test_power_rail_sequencer_cfg.sv */
// Purpose: Self-checking bench for the rail sequencer configuration block.
// Assumes: Inputs change on the falling clock edge; MS_CYCLES is 10.
// Notes:   Every strobe slot code is run through a power-up and power-down.
`timescale 1ns/1ps
`include "seq_cfg_map.svh"
module test_power_rail_sequencer_cfg;
    localparam int MS = 10;
    logic       clk_sys_i;
    logic       rst_b_i;
    logic       reg_wr_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic       unlocked_i;
    logic       power_up_trigger_i;
    logic       power_down_trigger_i;
    logic       instant_shutdown_select_i;
    logic [7:0] reg_rdata_o;
    logic [2:0] rail_en_o;
    logic [3:0] strobe_o;
    logic       busy_o;
    logic       trigger_clear_o;
    int         fail_count;
    int         total_checks;
    int         cyc;
    int         t_st[16];
    int         off_cyc[3];
    logic [3:0] on_st[3];
    logic [3:0] off_st[3];
    logic [3:0] last_st;
    logic [2:0] last_rail;
    logic [7:0] cur_dly;
    int         sq[9] = '{1, 2, 3, 4, 5, 6, 7, 14, 15};

    power_rail_sequencer_cfg #(.MS_CYCLES(MS)) dut_u (
        .clk_sys_i                 (clk_sys_i),
        .rst_b_i                   (rst_b_i),
        .reg_wr_i                  (reg_wr_i),
        .reg_addr_i                (reg_addr_i),
        .reg_wdata_i               (reg_wdata_i),
        .unlocked_i                (unlocked_i),
        .power_up_trigger_i        (power_up_trigger_i),
        .power_down_trigger_i      (power_down_trigger_i),
        .instant_shutdown_select_i (instant_shutdown_select_i),
        .reg_rdata_o               (reg_rdata_o),
        .rail_en_o                 (rail_en_o),
        .strobe_o                  (strobe_o),
        .busy_o                    (busy_o),
        .trigger_clear_o           (trigger_clear_o)
    );

    // Clock generation
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Records strobe change times and the strobe at each rail edge
    always @(negedge clk_sys_i) begin
        cyc = cyc + 1;
        if (strobe_o !== last_st) t_st[strobe_o] = cyc;
        for (int i = 0; i < 3; i++) begin
            if (rail_en_o[i] === 1'b1 && last_rail[i] !== 1'b1)
                on_st[i] = strobe_o;
            if (rail_en_o[i] === 1'b0 && last_rail[i] === 1'b1) begin
                off_st[i] = strobe_o;
                off_cyc[i] = cyc;
            end
        end
        last_st = strobe_o;
        last_rail = rail_en_o;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
        @(negedge clk_sys_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        repeat (2) @(negedge clk_sys_i);
        check("reg_rdata", 32'(reg_rdata_o), 32'(exp));
    endtask

    function automatic int ms_of(input logic [1:0] code);
        case (code)
            2'h0: return 1;
            2'h1: return 2;
            2'h2: return 5;
            default: return 10;
        endcase
    endfunction

    // Raises a trigger, waits for its clear pulse, then for idle
    task automatic trig(input logic up, input logic inst);
        int n;
        power_up_trigger_i = up;
        power_down_trigger_i = !up;
        instant_shutdown_select_i = inst;
        n = 0;
        while (trigger_clear_o !== 1'b1 && n < 5) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("trigger_clear", 32'(n < 5), 1);
        check("busy_start", 32'(busy_o), 32'(!inst));
        power_up_trigger_i = 1'b0;
        power_down_trigger_i = 1'b0;
        n = 0;
        while (busy_o !== 1'b0 && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("busy_end", 32'(busy_o), 0);
        check("strobe_idle", 32'(strobe_o), 0);
    endtask

    // Sets the three slots from one code, then runs up and down
    task automatic up_down(input logic [3:0] c);
        int         es[3];
        int         ms;
        int         d;
        logic [2:0] sb;
        sb = c[2:0] + 3'h3;
        es[0] = (c <= 4'h7 || c >= 4'he) ? int'(c) : 0;
        es[1] = int'(c[2:0]);
        es[2] = int'(sb);
        wr(`SEQ_ADDR_REGB_SWA, {c, 1'b0, c[2:0]});
        wr(`SEQ_ADDR_SWB, {1'b0, sb, 4'h0});
        rd(`SEQ_ADDR_REGB_SWA, {c, 1'b0, c[2:0]});
        for (int i = 0; i < 3; i++) begin
            on_st[i] = 4'h0;
            off_st[i] = 4'h0;
            off_cyc[i] = 0;
        end
        trig(1'b1, 1'b0);
        check("on_regb", 32'(on_st[0]), es[0]);
        check("on_swa", 32'(on_st[1]), es[1]);
        check("on_swb", 32'(on_st[2]), es[2]);
        for (int k = 0; k < 8; k++) begin
            ms = (k < 4) ? ms_of(2'(cur_dly >> (6 - 2 * k))) * MS : MS;
            d = t_st[sq[k + 1]] - t_st[sq[k]];
            check("strobe_gap", 32'(d >= ms && d <= ms + 3), 1);
        end
        trig(1'b0, 1'b0);
        check("rails_down", 32'(rail_en_o), 0);
        for (int i = 0; i < 3; i++) begin
            check("off_strobe", 32'(off_st[i]), es[i]);
            for (int j = 0; j < 3; j++)
                if (es[i] > es[j] && es[j] != 0)
                    check("order", 32'(off_cyc[i] < off_cyc[j]), 1);
        end
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        total_checks = 0;
        cyc = 0;
        rst_b_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        unlocked_i = 1'b1;
        power_up_trigger_i = 1'b0;
        power_down_trigger_i = 1'b0;
        instant_shutdown_select_i = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        rd(`SEQ_ADDR_REGB_SWA, 8'h00);
        rd(`SEQ_ADDR_SWB, 8'h40);
        rd(`SEQ_ADDR_DLY, 8'h00);
        rd(8'h1e, 8'h00);
        wr(`SEQ_ADDR_REGB_SWA, 8'hff);
        rd(`SEQ_ADDR_REGB_SWA, 8'hf7);
        wr(`SEQ_ADDR_SWB, 8'hff);
        rd(`SEQ_ADDR_SWB, 8'h70);
        unlocked_i = 1'b0;
        wr(`SEQ_ADDR_DLY, 8'hff);
        wr(`SEQ_ADDR_SWB, 8'h00);
        unlocked_i = 1'b1;
        rd(`SEQ_ADDR_DLY, 8'h00);
        rd(`SEQ_ADDR_SWB, 8'h70);
        cur_dly = 8'h1b;
        wr(`SEQ_ADDR_DLY, cur_dly);
        rd(`SEQ_ADDR_DLY, cur_dly);
        for (int c = 0; c < 16; c++)
            up_down(4'(c));
        trig(1'b1, 1'b0);
        check("rails_up", 32'(rail_en_o), 32'h7);
        trig(1'b0, 1'b1);
        @(negedge clk_sys_i);
        check("rails_instant", 32'(rail_en_o), 0);
        instant_shutdown_select_i = 1'b0;
        // Ordered power-down cut short by an instant shutdown
        trig(1'b1, 1'b0);
        power_down_trigger_i = 1'b1;
        @(negedge clk_sys_i);
        power_down_trigger_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        check("abort_busy", 32'(busy_o), 1);
        check("abort_rails", 32'(rail_en_o), 32'h6);
        power_down_trigger_i = 1'b1;
        instant_shutdown_select_i = 1'b1;
        @(negedge clk_sys_i);
        power_down_trigger_i = 1'b0;
        instant_shutdown_select_i = 1'b0;
        check("abort_clear", 32'(trigger_clear_o), 1);
        check("abort_off", 32'(rail_en_o), 0);
        check("abort_idle", 32'(busy_o), 0);
        finish_test();
    end
endmodule

/* verilog/power_rail_sequencer_cfg.sv */
// Purpose: Strobe slots for three rails, first four strobe delays, and
//          the strobe engine that switches those rails on and off.
// Assumes: Register port, unlock and triggers come from same-clock logic.
// Notes:   Reads return data one cycle after the address is presented.
//
// Summary of operation
// RULE_01 - Regulator b select, bits 7:4; 0 unsequenced, 1 to 7 pick strobe.
// RULE_02 - Codes 8,9 off; 10..13 reserved; 14 and 15 pick those strobes.
// RULE_03 - Switch a select, bits 2:0; 0 unsequenced, 1 to 7 pick strobe.
// RULE_04 - Switch b select bits 6:4, resets to strobe four, same encoding.
// RULE_05 - Delay register holds four 2-bit delays: 1, 2, 5 or 10 ms.
// RULE_06 - Switch b register resets to 0x40.
// RULE_07 - Reserved bits read zero and ignore writes.
// RULE_08 - Configuration writes take effect only while unlocked.
// RULE_09 - Trigger bits start sequences and are cleared by the device.
// RULE_10 - Shutdown hits sequenced rails only: reverse order, or all at once.
// RULE_11 - Power-up steps strobes upward, waiting the set delay between them.
`timescale 1ns/1ps
`include "seq_cfg_map.svh"
module power_rail_sequencer_cfg #(
    parameter int MS_CYCLES = `SEQ_MS_NS / `SEQ_CLK_PERIOD_NS
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       unlocked_i,
    input  wire logic       power_up_trigger_i,
    input  wire logic       power_down_trigger_i,
    input  wire logic       instant_shutdown_select_i,
    output logic [7:0]      reg_rdata_o,
    output logic [2:0]      rail_en_o,
    output logic [3:0]      strobe_o,
    output logic            busy_o,
    output logic            trigger_clear_o
);

    seq_cfg_pkg::seq_regs_s st_r;
    seq_cfg_pkg::seq_regs_s st_nxt;
    seq_cfg_pkg::reg_req_s  req;
    logic                   tmr_done;
    logic [3:0]             slot [3];
    logic [2:0]             hit;
    logic [2:0]             sequenced;
    logic [3:0]             next_up;
    logic [3:0]             next_dn;

    assign req = '{wr: reg_wr_i, addr: reg_addr_i, wdata: reg_wdata_i};

    // Field code to strobe number; zero means not under sequencer control
    function automatic logic [3:0] regb_slot(input logic [3:0] code);
        if (code <= `SEQ_STROBE_LAST_LOW || code >= `SEQ_STROBE_HIGH_A) begin
            regb_slot = code; // RULE_01 RULE_02
        end else begin
            regb_slot = 4'h0; // RULE_02
        end
    endfunction

    // Delay code that follows a given strobe
    function automatic logic [1:0] dly_code(input logic [7:0] d,
                                            input logic [3:0] s);
        case (s)
            4'h1:    dly_code = d[7:6]; // RULE_05
            4'h2:    dly_code = d[5:4];
            4'h3:    dly_code = d[3:2];
            4'h4:    dly_code = d[1:0];
            default: dly_code = 2'b00;
        endcase
    endfunction

    // Strobe slot of each rail
    assign slot[0] = regb_slot(st_r.cfg_regb_swa[`SEQ_REGB_MSB:`SEQ_REGB_LSB]);
    assign slot[1] = {1'b0,
                      st_r.cfg_regb_swa[`SEQ_SWA_MSB:`SEQ_SWA_LSB]}; // RULE_03
    assign slot[2] = {1'b0, st_r.swb_sel}; // RULE_04

    // Per-rail match against the current strobe
    for (genvar i = 0; i < 3; i++) begin : g_rail
        assign hit[i]       = (slot[i] == st_r.strobe);
        assign sequenced[i] = (slot[i] != 4'h0);
    end

    // Strobe stepping, skipping the unused gap between seven and fourteen
    assign next_up = (st_r.strobe == `SEQ_STROBE_LAST_LOW) ?
                     `SEQ_STROBE_HIGH_A : st_r.strobe + 4'h1;
    assign next_dn = (st_r.strobe == `SEQ_STROBE_HIGH_A) ?
                     `SEQ_STROBE_LAST_LOW : st_r.strobe - 4'h1;

    // Register port, read mux and strobe engine
    always_comb begin
        st_nxt          = st_r;
        st_nxt.trig_clr = 1'b0;
        st_nxt.tmr_go   = 1'b0;
        if (req.wr && unlocked_i) begin // RULE_08
            case (req.addr)
                `SEQ_ADDR_REGB_SWA: st_nxt.cfg_regb_swa =
                    req.wdata & 8'hf7; // RULE_07
                `SEQ_ADDR_SWB: st_nxt.swb_sel =
                    req.wdata[`SEQ_SWB_MSB:`SEQ_SWB_LSB]; // RULE_07
                `SEQ_ADDR_DLY: st_nxt.dly = req.wdata; // RULE_05
                default: ;
            endcase
        end
        case (req.addr)
            `SEQ_ADDR_REGB_SWA: st_nxt.rdata = st_r.cfg_regb_swa;
            `SEQ_ADDR_SWB:      st_nxt.rdata = {1'b0, st_r.swb_sel, 4'h0};
            `SEQ_ADDR_DLY:      st_nxt.rdata = st_r.dly;
            default:            st_nxt.rdata = 8'h00;
        endcase
        case (st_r.st)
            seq_cfg_pkg::SEQ_IDLE: begin
                if (power_down_trigger_i) begin
                    st_nxt.trig_clr = 1'b1; // RULE_09
                    if (instant_shutdown_select_i) begin
                        st_nxt.rails = st_r.rails & ~sequenced; // RULE_10
                    end else begin
                        st_nxt.st     = seq_cfg_pkg::SEQ_DOWN; // RULE_10
                        st_nxt.strobe = `SEQ_STROBE_HIGH_B;
                    end
                end else if (power_up_trigger_i) begin
                    st_nxt.trig_clr = 1'b1; // RULE_09
                    st_nxt.st       = seq_cfg_pkg::SEQ_UP; // RULE_11
                    st_nxt.strobe   = 4'h1;
                end
            end
            seq_cfg_pkg::SEQ_UP: begin
                if (!st_r.tmr_go && !tmr_done && st_r.strobe != 4'h0) begin
                    st_nxt.rails = st_r.rails | hit; // RULE_11
                end
                if (st_r.strobe == 4'h0) begin
                    st_nxt.strobe = 4'h1;
                end else if (tmr_done) begin
                    if (st_r.strobe == `SEQ_STROBE_HIGH_B) begin
                        st_nxt.st     = seq_cfg_pkg::SEQ_IDLE;
                        st_nxt.strobe = 4'h0;
                    end else begin
                        st_nxt.strobe = next_up; // RULE_11
                    end
                end
            end
            seq_cfg_pkg::SEQ_DOWN: begin
                if (power_down_trigger_i && instant_shutdown_select_i) begin
                    st_nxt.rails  = st_r.rails & ~sequenced; // RULE_10
                    st_nxt.st     = seq_cfg_pkg::SEQ_IDLE;
                    st_nxt.strobe = 4'h0;
                    st_nxt.trig_clr = 1'b1;
                end else begin
                    st_nxt.rails = st_r.rails & ~hit; // RULE_10
                    if (tmr_done) begin
                        if (st_r.strobe == 4'h1) begin
                            st_nxt.st     = seq_cfg_pkg::SEQ_IDLE;
                            st_nxt.strobe = 4'h0;
                        end else begin
                            st_nxt.strobe = next_dn; // RULE_10
                        end
                    end
                end
            end
            default: begin
                st_nxt.st = seq_cfg_pkg::SEQ_IDLE;
            end
        endcase
        // Start the delay whenever a new strobe is entered
        if (st_nxt.st != seq_cfg_pkg::SEQ_IDLE &&
            (st_nxt.strobe != st_r.strobe ||
             st_nxt.st != st_r.st)) begin
            st_nxt.tmr_go   = 1'b1;
            st_nxt.tmr_code = dly_code(st_r.dly, st_nxt.strobe); // RULE_05
        end
        // Busy kept in a flop so the output needs no decode
        st_nxt.busy = (st_nxt.st != seq_cfg_pkg::SEQ_IDLE);
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r              <= '0;
            st_r.st           <= seq_cfg_pkg::SEQ_IDLE;
            st_r.cfg_regb_swa <= `SEQ_RST_REGB_SWA;
            st_r.swb_sel      <= `SEQ_RST_SWB_SEL; // RULE_04 RULE_06
            st_r.dly          <= `SEQ_RST_DLY;
        end else begin
            st_r <= st_nxt;
        end
    end

    strobe_delay_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .go_i      (st_r.tmr_go),
        .code_i    (st_r.tmr_code),
        .done_o    (tmr_done)
    );

    assign reg_rdata_o     = st_r.rdata;
    assign rail_en_o       = st_r.rails;
    assign strobe_o        = st_r.strobe;
    assign busy_o          = st_r.busy;
    assign trigger_clear_o = st_r.trig_clr;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // Checks next to the engine
    a_locked_write: assert property (reg_wr_i && !unlocked_i |=> // RULE_08
        $stable(st_r.cfg_regb_swa) && $stable(st_r.dly)
        && $stable(st_r.swb_sel)) else $error("locked write changed cfg");
    a_swa_reserved: assert property (st_r.cfg_regb_swa[3] == 1'b0) // RULE_07
        else $error("reserved bit 3 set");
    a_swb_readback: assert property (reg_addr_i == `SEQ_ADDR_SWB |=> // RULE_07
        reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:0] == 4'h0)
        else $error("reserved swb bits read nonzero");
    a_trig_clear: assert property (!busy_o && // RULE_09
        (power_up_trigger_i || power_down_trigger_i) |=> trigger_clear_o)
        else $error("trigger not cleared");
    a_instant_off: assert property ( // RULE_10
        !busy_o && power_down_trigger_i &&
        instant_shutdown_select_i |=> (rail_en_o & sequenced) == 3'b000)
        else $error("instant shutdown left rail on");
    a_unseq_hold: assert property (!sequenced[0] && // RULE_02
        $stable(st_r.cfg_regb_swa) |=> $stable(rail_en_o[0]))
        else $error("unsequenced rail changed");
    a_up_first: assert property (!busy_o && !power_down_trigger_i && // RULE_11
        power_up_trigger_i && slot[1] == 4'h1 |-> ##3 rail_en_o[1])
        else $error("strobe one rail not enabled");
    a_dly_start: assert property ( // RULE_05
        st_r.tmr_go && st_r.strobe == 4'h2 |->
        st_r.tmr_code == st_r.dly[5:4]) else $error("wrong delay code");
    a_strobe_gap: assert property (busy_o && st_r.strobe == 4'h7 && // RULE_11
        tmr_done && st_r.st == seq_cfg_pkg::SEQ_UP |=> strobe_o == 4'he)
        else $error("strobe seven not followed by fourteen");

    c_power_up:   cover property (!busy_o && power_up_trigger_i);
    c_power_down: cover property (busy_o && st_r.st == seq_cfg_pkg::SEQ_DOWN
        && tmr_done);
    c_instant:    cover property (power_down_trigger_i &&
        instant_shutdown_select_i);
    c_unlocked:   cover property (reg_wr_i && unlocked_i);

endmodule

/* verilog/seq_cfg_map.svh */
// Purpose: Offsets, field positions, reset values and timing of the
//          rail sequencer configuration block.
// Assumes: 8-bit registers on the device's internal register port.
// Notes:   Definitions only.
`ifndef SEQ_CFG_MAP_SVH
`define SEQ_CFG_MAP_SVH

// Register offsets
`define SEQ_ADDR_REGB_SWA   8'h1b
`define SEQ_ADDR_SWB        8'h1c
`define SEQ_ADDR_DLY        8'h1d

// Field positions
`define SEQ_REGB_MSB        7
`define SEQ_REGB_LSB        4
`define SEQ_SWA_MSB         2
`define SEQ_SWA_LSB         0
`define SEQ_SWB_MSB         6
`define SEQ_SWB_LSB         4

// Reset values
`define SEQ_RST_REGB_SWA    8'h00
`define SEQ_RST_SWB_SEL     3'h4
`define SEQ_RST_SWB         8'h40
`define SEQ_RST_DLY         8'h00

// Strobe numbering
`define SEQ_STROBE_LAST_LOW 4'h7
`define SEQ_STROBE_HIGH_A   4'he
`define SEQ_STROBE_HIGH_B   4'hf
`define SEQ_DLY_FIELDS      4'h4

// Timing
`define SEQ_CLK_PERIOD_NS   10
`define SEQ_MS_NS           1000000
`define SEQ_DLY_MS_0        1
`define SEQ_DLY_MS_1        2
`define SEQ_DLY_MS_2        5
`define SEQ_DLY_MS_3        10

`endif

/* verilog/seq_cfg_pkg.sv */
// Purpose: Types shared by the rail sequencer configuration files.
// Assumes: Constants come from seq_cfg_map.svh.
// Notes:   State of each module travels as one packed struct.
package seq_cfg_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_UP   = 2'b01,
        SEQ_DOWN = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } reg_req_s;

    typedef struct packed {
        seq_state_e  st;
        logic [3:0]  strobe;
        logic [7:0]  cfg_regb_swa;
        logic [2:0]  swb_sel;
        logic [7:0]  dly;
        logic [2:0]  rails;
        logic [7:0]  rdata;
        logic        trig_clr;
        logic        tmr_go;
        logic [1:0]  tmr_code;
        logic        busy;
    } seq_regs_s;

    typedef struct packed {
        logic        run;
        logic [23:0] cnt;
        logic        done;
    } tmr_regs_s;

endpackage

/* verilog/strobe_delay_timer.sv */
// Purpose: Counts one inter-strobe delay of 1, 2, 5 or 10 ms.
// Assumes: go_i is a one-cycle pulse; a new go restarts the count.
// Notes:   done_o pulses one cycle when the delay has run out.
`timescale 1ns/1ps
`include "seq_cfg_map.svh"
module strobe_delay_timer #(
    parameter int MS_CYCLES = `SEQ_MS_NS / `SEQ_CLK_PERIOD_NS
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       go_i,
    input  wire logic [1:0] code_i,
    output logic            done_o
);

    seq_cfg_pkg::tmr_regs_s st_r;
    seq_cfg_pkg::tmr_regs_s st_nxt;
    logic [31:0]            load;

    // Delay code to cycle count, less one for the terminal cycle
    always_comb begin
        case (code_i)
            2'b00:   load = 32'(`SEQ_DLY_MS_0 * MS_CYCLES - 1);
            2'b01:   load = 32'(`SEQ_DLY_MS_1 * MS_CYCLES - 1);
            2'b10:   load = 32'(`SEQ_DLY_MS_2 * MS_CYCLES - 1);
            default: load = 32'(`SEQ_DLY_MS_3 * MS_CYCLES - 1);
        endcase
    end

    // Down counter with single done pulse
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (go_i) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = load[23:0];
        end else if (st_r.run) begin
            if (st_r.cnt == 24'h000000) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 24'h000001;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;

endmodule
